/* File: ips_pkg.sv */
// Constants for the interrupt priority select block.
// Assumes the core reaches the register over its own special function port.
package ips_pkg;

  localparam int          NUM_SRC       = 7;
  localparam logic [7:0]  PRIO_ADDR     = 8'hb8;
  localparam logic [7:0]  PRIO_RESET    = 8'h80;
  // Bit 7 is unused: it keeps its reset value and ignores writes.
  localparam logic [7:0]  PRIO_WR_MASK  = 8'h7f;
  localparam logic [2:0]  UNUSED_BIT    = 3'h7;

  // Bit positions, which are also the source numbers given to the core.
  localparam logic [2:0]  SRC_EXT0      = 3'h0;
  localparam logic [2:0]  SRC_TIMER0    = 3'h1;
  localparam logic [2:0]  SRC_EXT1      = 3'h2;
  localparam logic [2:0]  SRC_TIMER1    = 3'h3;
  localparam logic [2:0]  SRC_UART      = 3'h4;
  localparam logic [2:0]  SRC_TIMER2    = 3'h5;
  localparam logic [2:0]  SRC_SPI       = 3'h6;

  typedef logic [NUM_SRC-1:0] ips_src_t;

  typedef enum logic [1:0] {
    IPS_IDLE,
    IPS_LOW,
    IPS_HIGH,
    IPS_HIGH_OVER_LOW
  } ips_svc_e;

endpackage

/* File: ips_top.sv */
// Interrupt priority select: priority register, gating and level arbitration.
// Assumes requests, enables and the return strobe come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module ips_top
  import ips_pkg::*;
(
  input  wire logic              clk_sys,       // System clock.
  input  wire logic              rst_n,         // Async reset, active low.
  input  wire logic [7:0]        sfr_addr,      // Register address.
  input  wire logic              sfr_wr,        // Byte write strobe.
  input  wire logic [7:0]        sfr_wdata,     // Byte write data.
  input  wire logic              sfr_bit_wr,    // Single bit write strobe.
  input  wire logic [2:0]        sfr_bit_idx,   // Bit number for bit write.
  input  wire logic              sfr_bit_val,   // Value for bit write.
  input  wire logic              sfr_rd,        // Read strobe.
  output logic      [7:0]        sfr_rdata,     // Read data, next cycle.
  input  wire logic              global_enable, // Global interrupt enable.
  input  wire ips_pkg::ips_src_t irq_enable,    // Per source enables.
  input  wire ips_pkg::ips_src_t irq_req,       // Per source requests.
  input  wire logic              svc_return,    // Core finished a routine.
  output logic                   take_valid,    // Pulse: vector a source.
  output logic      [2:0]        take_src,      // Source being vectored.
  output logic                   take_high,     // Taken at high level.
  output logic      [7:0]        prio_levels,   // Register contents.
  output logic                   svc_high,      // High routine running.
  output logic                   svc_low        // Low routine running.
);
  import ips_pkg::*;

  logic [7:0]  interrupt_priority_levels_ff;
  logic [7:0]  rdata_ff;
  logic        take_ff;
  logic [2:0]  src_ff;
  logic        high_ff;
  ips_svc_e    svc_ff;
  ips_svc_e    nxt_svc;
  ips_src_t    gated;
  ips_src_t    hi_pend;
  ips_src_t    lo_pend;
  logic        grant;
  logic        grant_high;
  logic [2:0]  grant_src;
  logic        svc_high_ff;
  logic        svc_low_ff;

  // Lowest numbered pending source wins inside one level.
  function automatic logic [2:0] first_set(input ips_src_t v);
    logic [2:0] idx;
    idx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  wire logic wr_hit = sfr_wr && (sfr_addr == PRIO_ADDR);
  wire logic bit_hit = sfr_bit_wr && (sfr_addr == PRIO_ADDR)
                       && (sfr_bit_idx != UNUSED_BIT);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_priority_levels_ff <= PRIO_RESET;
    else if (wr_hit)
      interrupt_priority_levels_ff <= (sfr_wdata & PRIO_WR_MASK)
                                      | (PRIO_RESET & ~PRIO_WR_MASK);
    else if (bit_hit)
      interrupt_priority_levels_ff[sfr_bit_idx] <= sfr_bit_val;
  end

  // Unmapped reads return zero so other registers can be OR-ed in.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (sfr_rd && (sfr_addr == PRIO_ADDR))
      rdata_ff <= interrupt_priority_levels_ff;
    else
      rdata_ff <= '0;
  end

  always_comb
  begin
    gated   = irq_req & irq_enable & {NUM_SRC{global_enable}};
    hi_pend = gated & interrupt_priority_levels_ff[NUM_SRC-1:0];
    lo_pend = gated & ~interrupt_priority_levels_ff[NUM_SRC-1:0];
  end

  // A return strobe blocks a new grant for that cycle; the request is
  // seen again one cycle later, so nothing is lost.
  always_comb
  begin
    grant      = 1'b0;
    grant_high = 1'b0;
    grant_src  = '0;
    if (!svc_return)
    begin
      case (svc_ff)
        IPS_IDLE, IPS_LOW:
        begin
          if (|hi_pend)
          begin
            grant      = 1'b1;
            grant_high = 1'b1;
            grant_src  = first_set(hi_pend);
          end
          else if ((svc_ff == IPS_IDLE) && (|lo_pend))
          begin
            grant     = 1'b1;
            grant_src = first_set(lo_pend);
          end
        end
        default:
          grant = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    nxt_svc = svc_ff;
    case (svc_ff)
      IPS_IDLE:
        if (grant)
          nxt_svc = grant_high ? IPS_HIGH : IPS_LOW;
      IPS_LOW:
        if (svc_return)
          nxt_svc = IPS_IDLE;
        else if (grant)
          nxt_svc = IPS_HIGH_OVER_LOW;
      IPS_HIGH:
        if (svc_return)
          nxt_svc = IPS_IDLE;
      IPS_HIGH_OVER_LOW:
        if (svc_return)
          nxt_svc = IPS_LOW;
      default:
        nxt_svc = IPS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      svc_ff <= IPS_IDLE;
    else
      svc_ff <= nxt_svc;
  end

  // The service flags are decoded from the next state and registered, so
  // the core sees them from flops in the same cycle as the state itself.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svc_high_ff <= 1'b0;
      svc_low_ff  <= 1'b0;
    end
    else
    begin
      svc_high_ff <= (nxt_svc == IPS_HIGH) || (nxt_svc == IPS_HIGH_OVER_LOW);
      svc_low_ff  <= (nxt_svc == IPS_LOW) || (nxt_svc == IPS_HIGH_OVER_LOW);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      take_ff <= 1'b0;
      src_ff  <= '0;
      high_ff <= 1'b0;
    end
    else
    begin
      take_ff <= grant;
      if (grant)
      begin
        src_ff  <= grant_src;
        high_ff <= grant_high;
      end
    end
  end

  assign sfr_rdata   = rdata_ff;
  assign take_valid  = take_ff;
  assign take_src    = src_ff;
  assign take_high   = high_ff;
  assign prio_levels = interrupt_priority_levels_ff;
  assign svc_high    = svc_high_ff;
  assign svc_low     = svc_low_ff;

  a_spi_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_SPI)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_SPI]))
    else $error("Serial peripheral interrupt taken at wrong level.");

  a_timer2_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_TIMER2)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_TIMER2]))
    else $error("Timer 2 interrupt taken at wrong level.");

  a_uart_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_UART)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_UART]))
    else $error("UART interrupt taken at wrong level.");

  a_timer1_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_TIMER1)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_TIMER1]))
    else $error("Timer 1 interrupt taken at wrong level.");

  a_ext1_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_EXT1)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_EXT1]))
    else $error("External interrupt 1 taken at wrong level.");

  a_timer0_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_TIMER0)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_TIMER0]))
    else $error("Timer 0 interrupt taken at wrong level.");

  a_ext0_level: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && (src_ff == SRC_EXT0)
    |-> high_ff == $past(interrupt_priority_levels_ff[SRC_EXT0]))
    else $error("External interrupt 0 taken at wrong level.");

  a_enable_gate: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff |-> ((($past(irq_enable & irq_req) >> src_ff) & 7'h01) != 7'h00)
                && $past(global_enable))
    else $error("Interrupt taken from a disabled source.");

  a_high_first: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    take_ff && !high_ff |-> $past(hi_pend) == '0 && $past(svc_ff) == IPS_IDLE)
    else $error("Low level taken while high pending or busy.");

  a_no_low_preempt: assert property
    (@(posedge clk_sys) disable iff (!rst_n)
    svc_high && !svc_return |=> !take_ff)
    else $error("Interrupt taken during a high level routine.");

endmodule

`default_nettype wire

/* File: ips_core_model.sv */
// Core side model: pending flags and routine ends.
// Assumes the bench drives raise and ret_cmd on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module ips_core_model
  import ips_pkg::*;
(
  input  wire logic              clk_sys,    // System clock.
  input  wire logic              rst_n,      // Reset, active low.
  input  wire ips_pkg::ips_src_t raise,      // Flags to set.
  input  wire logic              ret_cmd,    // End the routine.
  input  wire logic              take_valid, // Vector pulse.
  input  wire logic [2:0]        take_src,   // Vectored source.
  output var ips_pkg::ips_src_t  irq_req,    // Pending flags.
  output logic                   svc_return  // Return pulse.
);
  // A flag is dropped when vectored, before the return, as a real core does.
  always @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_req    <= '0;
      svc_return <= 1'b0;
    end
    else
    begin
      irq_req    <= (irq_req | raise) &
                    ~(take_valid ? ips_src_t'(7'h01 << take_src) : '0);
      svc_return <= ret_cmd;
    end
  end
endmodule

`default_nettype wire

/* File: interrupt_priority_select_tb.sv */
// Self-checking bench for the interrupt priority select block.
// Assumes ips_core_model stands in for the core.
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_select_tb;
  import ips_pkg::*;
  logic       clk_sys, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd;
  logic       global_enable, svc_return, take_valid, take_high;
  logic       svc_high, svc_low, ret_cmd;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, prio_levels, d;
  logic [2:0] sfr_bit_idx, take_src;
  ips_src_t   irq_enable, irq_req, raise;
  int         mismatches, tests_run, cycles;

  ips_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .global_enable(global_enable),
    .irq_enable(irq_enable), .irq_req(irq_req), .svc_return(svc_return),
    .take_valid(take_valid), .take_src(take_src), .take_high(take_high),
    .prio_levels(prio_levels), .svc_high(svc_high), .svc_low(svc_low));
  ips_core_model i_core (.clk_sys(clk_sys), .rst_n(rst_n), .raise(raise),
    .ret_cmd(ret_cmd), .take_valid(take_valid), .take_src(take_src),
    .irq_req(irq_req), .svc_return(svc_return));

  task automatic chk(input string w, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic acc(input logic [7:0] a, input logic w, input logic b);
    sfr_addr = a;
    sfr_wr = w;
    sfr_bit_wr = b;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
    sfr_bit_wr = 1'b0;
    sfr_rd = 1'b1;
    @(negedge clk_sys);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic go(input ips_src_t m, input int n);
    raise <= m;
    @(negedge clk_sys);
    raise <= '0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic ret();
    ret_cmd <= 1'b1;
    @(negedge clk_sys);
    ret_cmd <= 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic take(input logic [2:0] s, input logic h);
    int n;
    n = 0;
    while (take_valid !== 1'b1 && n < 6)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("take_valid", {7'h0, take_valid}, 8'h01);
    chk("take_src", {5'h0, take_src}, {5'h0, s});
    chk("take_high", {7'h0, take_high}, {7'h0, h});
  endtask

  task automatic t_regs();
    sfr_wdata = 8'h00;
    acc(8'hb8, 1'b0, 1'b0);
    chk("reset", d, 8'h80);
    acc(8'hb8, 1'b1, 1'b0);
    chk("zero", d, 8'h80);
    sfr_wdata = 8'hff;
    acc(8'h12, 1'b1, 1'b0);
    chk("unmapped", d, 8'h00);
    acc(8'hb8, 1'b1, 1'b0);
    chk("ones", d, 8'hff);
    sfr_wdata = 8'h00;
    acc(8'hb8, 1'b1, 1'b0);
  endtask

  task automatic t_levels();
    for (int i = 0; i < 14; i++)
    begin
      sfr_bit_idx = 3'(i / 2);
      sfr_bit_val = 1'(i);
      acc(8'hb8, 1'b0, 1'b1);
      // Bits set by earlier passes stay set until the closing clear.
      chk("levels", prio_levels, 8'h80 | ((8'h01 << (i / 2)) - 8'h01)
          | (8'(i % 2) << (i / 2)));
      go(ips_src_t'(7'h01 << (i / 2)), 0);
      take(3'(i / 2), 1'(i));
      chk("svc_high", {7'h0, svc_high}, 8'(i % 2));
      ret();
    end
    sfr_wdata = 8'h00;
    acc(8'hb8, 1'b1, 1'b0);
    chk("cleared", d, 8'h80);
  endtask

  task automatic t_enable();
    irq_enable = 7'h7b;
    go(7'h04, 5);
    chk("masked", {6'h0, svc_high, svc_low}, 8'h00);
    irq_enable = 7'h7f;
    global_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("global_off", {5'h0, take_valid, svc_high, svc_low}, 8'h00);
    global_enable = 1'b1;
    take(3'h2, 1'b0);
    ret();
  endtask

  task automatic t_preempt();
    sfr_wdata = 8'h40;
    acc(8'hb8, 1'b1, 1'b0);
    go(7'h03, 0);
    take(3'h0, 1'b0);
    go(7'h40, 0);
    take(3'h6, 1'b1);
    go(7'h20, 5);
    chk("nested", {3'h0, svc_high, svc_low, take_src}, 8'h1e);
    ret();
    chk("back_low", {3'h0, svc_high, svc_low, take_src}, 8'h0e);
    ret();
    take(3'h1, 1'b0);
    ret();
    take(3'h5, 1'b0);
    ret();
  endtask

  // A reset in mid-run must restore the register and the service state.
  task automatic t_reset();
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk("rst_levels", prio_levels, 8'h80);
    chk("rst_take", {3'h0, take_valid, take_high, take_src}, 8'h00);
    chk("rst_svc", {6'h0, svc_high, svc_low}, 8'h00);
    rst_n = 1'b1;
    go(7'h01, 0);
    take(3'h0, 1'b0);
    ret();
  endtask

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, ret_cmd} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_idx, raise} = '0;
    {mismatches, tests_run, cycles} = '0;
    global_enable = 1'b1;
    irq_enable = 7'h7f;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_regs();
    t_levels();
    t_enable();
    t_preempt();
    t_reset();
    tally_and_finish();
  end
endmodule

`default_nettype wire
